// ### hdl/cpim_pkg.sv
// Contract
// [R1] user pattern memory holds 32 glyphs
// [R2] user glyph shown for codes 00h to 1Fh
// [R3] code bits 0-4 form address bits 3-7
// [R4] address bits 0-2 pick row; eighth unused
// [R5] data bits 0-4 are dots, bit4 leftmost
// [R6] code bits 5-7 zero selects user pattern
// [R7] pattern one lights dot, zero clears it
// [R8] sixty icons, one bit each
// [R9] icon words 10h-1Bh, D4 first, D7-D5 zero
// [R10] every sixth segment carries no icon
// [R11] reset leaves icon memory untouched
// [R12] host writes icons before display on
// [R13] icons ignore display shift
// [R14] host avoids icon addresses 1Ch and 1Dh
// [R15] refresh reads apart from host writes
// [R16] eight common and 71 segment lines
// [R17] fetched data latched into segment registers
// [R18] blank column on every sixth segment
// [R19] blank columns scroll with characters
package cpim_pkg;

   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int COM_NUM      = 8;
   localparam int SEG_NUM      = 71;
   localparam int GLYPH_NUM    = 32;
   localparam int GLYPH_COLS   = 5;
   localparam int SLOT_COLS    = 6;
   localparam int SLOT_NUM     = 13;
   localparam int CHAR_DEPTH   = 14;
   localparam int ICON_WORDS   = 12;
   localparam int ROW_BUF_W    = SLOT_NUM * SLOT_COLS;
   localparam logic [2:0] ICON_ROW  = 3'h7;
   localparam logic [2:0] LAST_ROW  = 3'h7;
   localparam logic [3:0] LAST_SLOT = 4'hC;
   localparam logic [2:0] MAX_DOT   = 3'h5;

   // ---------------------------------------------------------------
   // host address map
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_CHAR    = 2'h0;
   localparam logic [1:0] SEL_PATTERN = 2'h1;
   localparam logic [1:0] SEL_ICON    = 2'h2;
   localparam logic [7:0] ICON_BASE   = 8'h10;
   localparam logic [7:0] ICON_TOP    = 8'h1D;
   localparam logic [4:0] CHAR_TOP    = 5'h0D;
   localparam logic [2:0] USER_CODE_HI = 3'h0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int ROW_TIME_NS   = 1000;
   localparam int ROW_CYCLES    = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // refresh sequencer
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_CHAR = 4'h1,
      ST_CODE = 4'h2,
      ST_PAT  = 4'h4,
      ST_HOLD = 4'h8
   } cpim_state_type;

endpackage

// ### hdl/cpim_mem.sv
`timescale 1ns/100ps
module cpim_mem #(
   parameter int AW = 4,
   parameter int DW = 8
) (
   input  wire logic          ref_clk_in,
   input  wire logic          nrst_in,
   input  wire logic          wr_en_in,
   input  wire logic [AW-1:0] wr_addr_in,
   input  wire logic [DW-1:0] wr_data_in,
   input  wire logic [AW-1:0] rd_addr_in,
   output logic      [DW-1:0] rd_data_out
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [DW-1:0] mem_q [0:(1<<AW)-1];

   // array has no reset: contents stay as written across resets
   always_ff @(posedge ref_clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
   end

   // separate read port so refresh never waits on a host write
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= mem_q[rd_addr_in];
      end
   end

endmodule // cpim_mem

// ### hdl/cpim_display.sv
`timescale 1ns/100ps
module cpim_display #(
   parameter int ROW_CYCLES = cpim_pkg::ROW_CYCLES
) (
   input  wire logic                         ref_clk_in,
   input  wire logic                         nrst_in,
   input  wire logic                         host_wr_in,
   input  wire logic [1:0]                   host_sel_in,
   input  wire logic [7:0]                   host_addr_in,
   input  wire logic [7:0]                   host_data_in,
   input  wire logic                         disp_on_in,
   input  wire logic [3:0]                   char_shift_in,
   input  wire logic [2:0]                   dot_shift_in,
   input  wire logic [4:0]                   font_row_in,
   output logic      [10:0]                  font_addr_out,
   output logic      [cpim_pkg::COM_NUM-1:0] com_out,
   output logic      [cpim_pkg::SEG_NUM-1:0] seg_out
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   cpim_pkg::cpim_state_type          st_q;
   logic [2:0]                        row_q;
   logic [3:0]                        slot_q;
   logic [7:0]                        hold_cnt_q;
   logic [3:0]                        shift_q;
   logic [2:0]                        dot_q;
   logic [7:0]                        code_q;
   logic [cpim_pkg::ROW_BUF_W-1:0]    row_buf_q;
   logic [cpim_pkg::ROW_BUF_W-1:0]    shifted;
   logic                              icon_row;
   logic [4:0]                        char_sum;
   logic [3:0]                        char_raddr;
   logic [7:0]                        upm_raddr;
   logic [3:0]                        icon_raddr;
   logic [7:0]                        dcm_rd;
   logic [4:0]                        upm_rd;
   logic [4:0]                        icon_rd;
   logic [4:0]                        pat_bits;
   logic                              user_code;
   logic                              dcm_we;
   logic                              upm_we;
   logic                              icon_we;
   logic [7:0]                        icon_off;
   logic [cpim_pkg::SEG_NUM-1:0]      blank_mask;

   assign icon_row = (row_q == cpim_pkg::ICON_ROW);

   // ---------------------------------------------------------------
   // host write decode
   // ---------------------------------------------------------------
   // host port is the write side of each memory; refresh owns the read side
   assign dcm_we   = host_wr_in && (host_sel_in == cpim_pkg::SEL_CHAR)
                     && (host_addr_in[7:4] == 4'h0)
                     && (host_addr_in[3:0] <= cpim_pkg::CHAR_TOP[3:0]);     // [R15]
   assign upm_we   = host_wr_in && (host_sel_in == cpim_pkg::SEL_PATTERN);  // [R1]
   // 1Ch and 1Dh take writes but no icon segment ever reads them
   assign icon_we  = host_wr_in && (host_sel_in == cpim_pkg::SEL_ICON)
                     && (host_addr_in >= cpim_pkg::ICON_BASE)
                     && (host_addr_in <= cpim_pkg::ICON_TOP);               // [R14]
   assign icon_off = host_addr_in - cpim_pkg::ICON_BASE;

   // ---------------------------------------------------------------
   // refresh read addresses
   // ---------------------------------------------------------------
   // character area wraps inside the 14 stored codes when shifted
   assign char_sum   = {1'b0, slot_q} + {1'b0, shift_q};
   assign char_raddr = (char_sum > cpim_pkg::CHAR_TOP) ?
                       4'(char_sum - 5'(cpim_pkg::CHAR_DEPTH)) : char_sum[3:0];
   // code bits 4:0 give the glyph slot, the row gives the line
   assign upm_raddr  = {dcm_rd[4:0], row_q};                                // [R3] [R4]
   // icons are read by fixed slot, the display shift never applies
   assign icon_raddr = slot_q;                                              // [R13]

   // ---------------------------------------------------------------
   // memories
   // ---------------------------------------------------------------
   cpim_mem #(.AW(4), .DW(8)) u_char_mem (
      .ref_clk_in  (ref_clk_in),
      .nrst_in     (nrst_in),
      .wr_en_in    (dcm_we),
      .wr_addr_in  (host_addr_in[3:0]),
      .wr_data_in  (host_data_in),
      .rd_addr_in  (char_raddr),
      .rd_data_out (dcm_rd)
   );

   // 256 words of five dots: 32 glyphs of eight lines
   cpim_mem #(.AW(8), .DW(cpim_pkg::GLYPH_COLS)) u_pattern_mem (
      .ref_clk_in  (ref_clk_in),
      .nrst_in     (nrst_in),
      .wr_en_in    (upm_we),
      .wr_addr_in  (host_addr_in),
      .wr_data_in  (host_data_in[4:0]),
      .rd_addr_in  (upm_raddr),
      .rd_data_out (upm_rd)
   );

   // icon words hold D4..D0 only; D7..D5 are dropped on write
   cpim_mem #(.AW(4), .DW(cpim_pkg::GLYPH_COLS)) u_icon_mem (
      .ref_clk_in  (ref_clk_in),
      .nrst_in     (nrst_in),
      .wr_en_in    (icon_we),
      .wr_addr_in  (icon_off[3:0]),
      .wr_data_in  (host_data_in[4:0]),
      .rd_addr_in  (icon_raddr),
      .rd_data_out (icon_rd)
   );                                                                       // [R9] [R11]

   // ---------------------------------------------------------------
   // pattern select
   // ---------------------------------------------------------------
   // user glyph only for codes 00h..1Fh, fixed font otherwise
   assign user_code = (code_q[7:5] == cpim_pkg::USER_CODE_HI);              // [R2] [R6]
   always_comb begin
      if (icon_row) begin
         pat_bits = (slot_q < 4'(cpim_pkg::ICON_WORDS)) ? icon_rd : 5'h00;  // [R8]
      end else if (user_code) begin
         pat_bits = upm_rd;                                                 // [R6] [R7]
      end else begin
         pat_bits = font_row_in;
      end
   end

   // ---------------------------------------------------------------
   // refresh sequencer
   // ---------------------------------------------------------------
   // fixed three-step fetch per slot; host traffic never stalls it
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= cpim_pkg::ST_CHAR;
      end else begin
         unique case (st_q)
            cpim_pkg::ST_CHAR: st_q <= cpim_pkg::ST_CODE;                   // [R15]
            cpim_pkg::ST_CODE: st_q <= cpim_pkg::ST_PAT;
            cpim_pkg::ST_PAT: begin
               if (slot_q == cpim_pkg::LAST_SLOT) begin
                  st_q <= cpim_pkg::ST_HOLD;
               end else begin
                  st_q <= cpim_pkg::ST_CHAR;
               end
            end
            cpim_pkg::ST_HOLD: begin
               if (hold_cnt_q == 8'(ROW_CYCLES - 1)) begin
                  st_q <= cpim_pkg::ST_CHAR;
               end
            end
         endcase
      end
   end

   // slot and row counters
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         slot_q <= 4'h0;
         row_q  <= 3'h0;
      end else if (st_q == cpim_pkg::ST_PAT) begin
         slot_q <= (slot_q == cpim_pkg::LAST_SLOT) ? 4'h0 : slot_q + 4'h1;
      end else if ((st_q == cpim_pkg::ST_HOLD) && (hold_cnt_q == 8'(ROW_CYCLES - 1))) begin
         row_q <= (row_q == cpim_pkg::LAST_ROW) ? 3'h0 : row_q + 3'h1;
      end
   end

   // row hold counter sets the multiplex period of each common
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hold_cnt_q <= 8'h00;
      end else if (st_q == cpim_pkg::ST_HOLD) begin
         hold_cnt_q <= (hold_cnt_q == 8'(ROW_CYCLES - 1)) ? 8'h00 : hold_cnt_q + 8'h01;
      end
   end

   // scroll offsets are taken on the last hold cycle of the icon row: the
   // first character read of a frame already uses them, so no frame tears
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shift_q <= 4'h0;
         dot_q   <= 3'h0;
      end else if ((st_q == cpim_pkg::ST_HOLD) && (row_q == cpim_pkg::LAST_ROW)
                   && (hold_cnt_q == 8'(ROW_CYCLES - 1))) begin
         shift_q <= (char_shift_in > cpim_pkg::CHAR_TOP[3:0]) ? 4'h0 : char_shift_in;
         dot_q   <= (dot_shift_in > cpim_pkg::MAX_DOT) ? cpim_pkg::MAX_DOT : dot_shift_in;
      end
   end

   // code capture and fixed font request
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         code_q        <= 8'h00;
         font_addr_out <= 11'h000;
      end else if (st_q == cpim_pkg::ST_CODE) begin
         code_q        <= dcm_rd;
         font_addr_out <= {dcm_rd, row_q};
      end
   end

   // ---------------------------------------------------------------
   // row buffer
   // ---------------------------------------------------------------
   // five dots then one forced blank per slot, bit 4 leftmost
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         row_buf_q <= '0;
      end else if (st_q == cpim_pkg::ST_PAT) begin
         for (int c = 0; c < cpim_pkg::GLYPH_COLS; c++) begin
            row_buf_q[slot_q*cpim_pkg::SLOT_COLS + c] <= pat_bits[4-c];    // [R5] [R7]
         end
         row_buf_q[slot_q*cpim_pkg::SLOT_COLS + cpim_pkg::GLYPH_COLS] <= 1'b0; // [R18]
      end
   end

   // ---------------------------------------------------------------
   // segment and common latches
   // ---------------------------------------------------------------
   // blanks live in the buffer, so the dot shift carries them along
   assign shifted = icon_row ? row_buf_q : (row_buf_q >> dot_q);            // [R19] [R13]

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         seg_out <= '0;
         com_out <= '0;
      end else if ((st_q == cpim_pkg::ST_PAT) && (slot_q == cpim_pkg::LAST_SLOT)) begin
         seg_out <= '0;
         com_out <= '0;
      end else if ((st_q == cpim_pkg::ST_HOLD) && (hold_cnt_q == 8'h00)) begin
         seg_out <= disp_on_in ? shifted[cpim_pkg::SEG_NUM-1:0] : '0;       // [R17] [R16]
         com_out <= disp_on_in ? (8'h01 << row_q) : 8'h00;                  // [R16]
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   generate
      for (genvar k = 0; k < cpim_pkg::SEG_NUM; k++) begin : g_mask
         assign blank_mask[k] = ((k % cpim_pkg::SLOT_COLS) == cpim_pkg::GLYPH_COLS);
      end
   endgenerate

   sequence s_fetch;
      (st_q == cpim_pkg::ST_CHAR) ##1 (st_q == cpim_pkg::ST_CODE) ##1 (st_q == cpim_pkg::ST_PAT);
   endsequence

   sequence s_latch;
      (st_q == cpim_pkg::ST_HOLD) && (hold_cnt_q == 8'h00) && disp_on_in;
   endsequence

   a_fetch_steady: assert property ((st_q == cpim_pkg::ST_CHAR) && host_wr_in |-> s_fetch) // [R15]
      else $error("refresh fetch disturbed by host write");
   a_user_addr: assert property ((st_q == cpim_pkg::ST_PAT) && !icon_row && user_code
                                 |-> $past(upm_raddr[7:3]) == code_q[4:0])  // [R3]
      else $error("user pattern slot does not follow code");
   a_row_unused: assert property ((st_q == cpim_pkg::ST_CODE) && !icon_row
                                  |-> upm_raddr[2:0] != cpim_pkg::ICON_ROW) // [R4]
      else $error("eighth glyph line fetched for display");
   a_font_pick: assert property ((st_q == cpim_pkg::ST_PAT) && !icon_row && !user_code
                                 |-> pat_bits == font_row_in)               // [R6]
      else $error("fixed font not used for high code");
   // unwritten memories read unknown, so dot checks start at display on
   a_left_dot: assert property ((st_q == cpim_pkg::ST_PAT) && disp_on_in
                                |=> row_buf_q[$past(slot_q)*cpim_pkg::SLOT_COLS]
                                    == $past(pat_bits[4]))                  // [R5]
      else $error("bit 4 not leftmost dot");
   a_icon_gap: assert property ((s_latch and icon_row)
                                |=> (seg_out & blank_mask) == '0)           // [R10]
      else $error("icon driven on sixth segment");
   a_slot_blank: assert property ((st_q == cpim_pkg::ST_PAT)
                                  |=> row_buf_q[$past(slot_q)*cpim_pkg::SLOT_COLS
                                                + cpim_pkg::GLYPH_COLS] == 1'b0) // [R18]
      else $error("separator column not blank");
   a_seg_latch: assert property ((s_latch and !icon_row)                    // [R17] [R19]
                                 |=> seg_out == $past(row_buf_q[dot_q +: cpim_pkg::SEG_NUM]))
      else $error("segment latch mismatch");
   a_com_single: assert property (s_latch |=> $onehot(com_out) && com_out[$past(row_q)]) // [R16]
      else $error("common select wrong");
   a_icon_fixed: assert property ((st_q == cpim_pkg::ST_CHAR) && icon_row
                                  |-> icon_raddr == slot_q)                 // [R13]
      else $error("icon read shifted");

   // display off must leave both latches dark at the row latch
   a_off_blank: assert property ((st_q == cpim_pkg::ST_HOLD) && (hold_cnt_q == 8'h00) // [R17]
                                 && !disp_on_in |=> (seg_out == '0) && (com_out == '0))
      else $error("outputs not blank with display off");

   // slot 12 has no icon word behind it, so its dots stay off
   a_icon_tail: assert property ((st_q == cpim_pkg::ST_PAT) && icon_row    // [R8]
                                 && (slot_q == cpim_pkg::LAST_SLOT) |-> pat_bits == 5'h00)
      else $error("icon dots beyond the last icon word");

   // the dot offset never exceeds the clamp
   a_dot_range: assert property (dot_q <= cpim_pkg::MAX_DOT)                // [R19]
      else $error("dot shift beyond clamp");
   // the character offset only moves between frames
   a_shift_frame: assert property ((st_q != cpim_pkg::ST_HOLD) |=> $stable(shift_q)) // [R19]
      else $error("character shift moved inside a frame");

   // font request carries the captured code and current line
   a_font_req: assert property ((st_q == cpim_pkg::ST_PAT)                  // [R6]
                                |-> font_addr_out == {code_q, row_q})
      else $error("font request out of step with code");

endmodule // cpim_display

// ### verif/cpim_host_model.sv
`timescale 1ns/100ps
module cpim_host_model (
   input  wire logic        ref_clk_in,
   input  wire logic [10:0] font_addr_in,
   output logic      [4:0]  font_row_out,
   output logic             host_wr_out,
   output logic      [1:0]  host_sel_out,
   output logic      [7:0]  host_addr_out,
   output logic      [7:0]  host_data_out
);
   // ---------------------------------------------------------------
   // fixed font stand-in
   // ---------------------------------------------------------------
   // answers at once; row word mixes code and line so a mispaired fetch shows
   assign font_row_out = (font_addr_in[7:3] ^ {font_addr_in[10:8], font_addr_in[1:0]})
                         + {2'h0, font_addr_in[2:0]};

   // ---------------------------------------------------------------
   // host write port
   // ---------------------------------------------------------------
   // bus idle at time zero
   initial begin
      host_wr_out   = 1'b0;
      host_sel_out  = 2'h3;
      host_addr_out = 8'h00;
      host_data_out = 8'h00;
   end

   // one write per call, none for icon 1Ch or 1Dh; calls back to back keep the strobe up
   task automatic write_byte(input logic [1:0] sel, input logic [7:0] addr,
                             input logic [7:0] data);
      if (sel == 2'h2 && (addr == 8'h1C || addr == 8'h1D)) begin
         return;
      end
      @(negedge ref_clk_in);
      host_wr_out   = 1'b1;
      host_sel_out  = sel;
      host_addr_out = addr;
      host_data_out = data;
   endtask

   // released bus shows inverted values so a stale sample cannot pass
   task automatic release_bus();
      @(negedge ref_clk_in);
      host_wr_out   = 1'b0;
      host_addr_out = ~host_addr_out;
      host_data_out = ~host_data_out;
   endtask
endmodule // cpim_host_model

// ### verif/char_pattern_icon_memory_tb.sv
`timescale 1ns/100ps
module char_pattern_icon_memory_tb;
   // ---------------------------------------------------------------
   // signals and reference state
   // ---------------------------------------------------------------
   localparam int RC = 4;
   logic                         ref_clk_in = 1'b0;
   logic                         nrst_in;
   logic                         disp_on_in;
   logic [3:0]                   char_shift_in;
   logic [2:0]                   dot_shift_in;
   logic                         host_wr;
   logic [1:0]                   host_sel;
   logic [7:0]                   host_addr;
   logic [7:0]                   host_data;
   logic [4:0]                   font_row;
   logic [10:0]                  font_addr;
   logic [cpim_pkg::COM_NUM-1:0] com_out;
   logic [cpim_pkg::SEG_NUM-1:0] seg_out;
   int                           n_errors = 0;
   int                           cmp_count = 0;
   int                           char_m[14];
   int                           pat_m[256];
   int                           icon_m[12];

   // free running clock, 10 ns period
   always #5 ref_clk_in = ~ref_clk_in;

   // short row hold keeps frames brief
   cpim_display #(.ROW_CYCLES(RC)) cpim_display_inst (
      .ref_clk_in   (ref_clk_in),
      .nrst_in      (nrst_in),
      .host_wr_in   (host_wr),
      .host_sel_in  (host_sel),
      .host_addr_in (host_addr),
      .host_data_in (host_data),
      .disp_on_in   (disp_on_in),
      .char_shift_in(char_shift_in),
      .dot_shift_in (dot_shift_in),
      .font_row_in  (font_row),
      .font_addr_out(font_addr),
      .com_out      (com_out),
      .seg_out      (seg_out)
   );

   cpim_host_model cpim_host_model_inst (
      .ref_clk_in   (ref_clk_in),
      .font_addr_in (font_addr),
      .font_row_out (font_row),
      .host_wr_out  (host_wr),
      .host_sel_out (host_sel),
      .host_addr_out(host_addr),
      .host_data_out(host_data)
   );

   // ---------------------------------------------------------------
   // reporting
   // ---------------------------------------------------------------
   task automatic check(input logic [70:0] seen, input logic [70:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // reference model
   // ---------------------------------------------------------------
   // same rows as the font stand-in, worked out with integers
   function automatic int font_exp(input int code, input int line);
      return (((code & 31) ^ (((code >> 5) << 2) | (line & 3))) + line) & 31;
   endfunction

   // writes go to the port and, where accepted, to the model
   task automatic host_write(input logic [1:0] sel, input logic [7:0] a, input logic [7:0] d);
      cpim_host_model_inst.write_byte(sel, a, d);
      if (sel == 2'h0 && a <= 8'h0D) begin
         char_m[a] = d;
      end else if (sel == 2'h1) begin
         pat_m[a] = d & 8'h1F;
      end else if (sel == 2'h2 && a >= 8'h10 && a <= 8'h1B) begin
         icon_m[a - 8'h10] = d & 8'h1F;
      end
   endtask

   function automatic logic [70:0] exp_seg(input int row, input int s, input int d);
      logic [77:0] line_buf;
      logic [70:0] seg;
      int          code;
      int          p;
      line_buf = '0;
      for (int i = 0; i < 13; i++) begin
         code = char_m[(i + s) % 14];
         p = (code < 32) ? pat_m[code * 8 + row] : font_exp(code, row);
         for (int c = 0; c < 5; c++) begin
            line_buf[6 * i + c] = p[4 - c];
         end
      end
      for (int j = 0; j < 71; j++) begin
         if (row == 7) begin
            seg[j] = (j % 6 == 5) ? 1'b0 : icon_m[j / 6][4 - j % 6];
         end else begin
            seg[j] = line_buf[j + d];
         end
      end
      return seg;
   endfunction

   // bounded wait for a given common line to be latched
   task automatic wait_row(input int r);
      int k;
      k = 0;
      while (com_out !== 8'(1 << r) && k < 1000) begin
         @(negedge ref_clk_in);
         k++;
      end
      if (com_out !== 8'(1 << r)) begin
         n_errors++;
         final_report();
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   // passes: plain, far limits, random, out of range values, display off
   initial begin
      int seed;
      int sh;
      int dt;
      nrst_in = 1'b0;
      disp_on_in = 1'b0;
      char_shift_in = 4'h0;
      dot_shift_in = 3'h0;
      seed = $urandom(49);
      repeat (8) @(negedge ref_clk_in);
      nrst_in = 1'b1;
      check(71'($bits(seg_out)), 71'(71));
      check(71'($bits(com_out)), 71'(8));
      for (int t = 0; t < 5; t++) begin
         sh = (t == 1) ? 13 : (t == 2) ? $urandom % 14 : (t == 3) ? 15 : 0;
         dt = (t == 1) ? 5 : (t == 2) ? $urandom % 6 : (t == 3) ? 7 : 0;
         for (int a = 0; a < 14; a++) begin
            host_write(2'h0, 8'(a), ($urandom % 2) ? 8'($urandom % 32) : 8'($urandom));
         end
         for (int a = 0; a < 256; a++) begin
            host_write(2'h1, 8'(a), 8'($urandom));
         end
         for (int a = 0; a < 12; a++) begin
            host_write(2'h2, 8'(16 + a), 8'($urandom));
         end
         // refused writes; 10h and 20h alias valid places if decoding is short
         host_write(2'h3, 8'h00, 8'hFF);
         host_write(2'h0, 8'h10, 8'hFF);
         host_write(2'h2, 8'h20, 8'hFF);
         host_write(2'h2, 8'h0F, 8'hFF);
         cpim_host_model_inst.release_bus();
         // let refresh run past one full row period before the inputs change
         repeat (50) @(negedge ref_clk_in);
         char_shift_in = 4'(sh);
         dot_shift_in = 3'(dt);
         disp_on_in = (t != 4);
         sh = (sh > 13) ? 0 : sh;
         dt = (dt > 5) ? 5 : dt;
         if (t == 4) begin
            repeat (100) @(negedge ref_clk_in);
            repeat (300) begin
               @(negedge ref_clk_in);
               check(71'(seg_out) | 71'(com_out), 71'h0);
            end
         end else begin
            wait_row(0);
            wait_row(7);
            for (int r = 0; r < 8; r++) begin
               // writes to hidden places while the row refresh runs
               host_write(2'h0, 8'((13 + sh) % 14), 8'($urandom));
               host_write(2'h1, 8'($urandom) | 8'h07, 8'($urandom));
               cpim_host_model_inst.release_bus();
               wait_row(r);
               check(seg_out, exp_seg(r, sh, dt));
            end
         end
      end
      // mid-run reset: stored codes and icons must survive it
      @(negedge ref_clk_in);
      nrst_in = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      nrst_in = 1'b1;
      disp_on_in = 1'b1;
      wait_row(0);
      check(seg_out, exp_seg(0, 0, 0));
      wait_row(7);
      check(seg_out, exp_seg(7, 0, 0));
      final_report();
   end
endmodule // char_pattern_icon_memory_tb
